// File: sme_pkg.sv
// Shared constants for management-mode entry, save and resume
package sme_pkg;
    localparam logic [31:0] BASE_RESET = 32'h0003_0000;
    localparam logic [31:0] SAVE_OFS = 32'h0000_fe00;
    localparam logic [31:0] ENTRY_OFS = 32'h0000_8000;
    localparam int SAVE_BYTES = 512;
    localparam int WORD_BYTES = 4;
    localparam int SAVE_WORDS = SAVE_BYTES / WORD_BYTES;
    localparam int IDX_W = 7;
    localparam logic [IDX_W-1:0] IDX_LAST = 7'h7f;
    localparam logic [IDX_W-1:0] IDX_RESTART = 7'h32;
    localparam logic [IDX_W-1:0] IDX_REVISION = 7'h3f;
    localparam logic [IDX_W-1:0] IDX_BASE = 7'h40;
    localparam int REV_RELOC_BIT = 17;
    // Arbitrary revision code; bit for relocation is forced on top
    localparam logic [31:0] REV_ID_CODE = 32'h0000_0001;
    localparam int SEL_SHIFT = 4;
    localparam int REAL_ADDR_W = 21;
    localparam logic [REAL_ADDR_W-1:0] REAL_ADDR_MAX = 21'h10ffef;
    localparam longint REGION_DEFAULT = 64'h0000_0000_0001_0000;
    localparam longint REGION_MIN = 64'h0000_0000_0000_8000;
    localparam longint REGION_MAX = 64'h0000_0001_0000_0000;
    localparam logic [31:0] BACKED_BYTES = 32'h0000_8000;
endpackage : sme_pkg

// File: sme_link_if.sv
// Link between processor management control and system logic
interface sme_link_if;
    logic mgmt_interrupt;
    logic system_mgmt_mode;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata;
    logic mem_ack;
    modport core (input mgmt_interrupt, output system_mgmt_mode, output mem_req,
        output mem_we, output mem_addr, output mem_wdata, input mem_rdata, input mem_ack);
    modport sys (output mgmt_interrupt, input system_mgmt_mode, input mem_req,
        input mem_we, input mem_addr, input mem_wdata, output mem_rdata, output mem_ack);
endinterface : sme_link_if

// File: sme_core_end.sv
// Processor end: management-mode entry, state save, resume and addressing
// Overview of operation
// - Reset loads base register with 30000h
// - Save at base+FE00h, fetch at base+8000h
// - Save area is top 512 region bytes
// - Region 64K default, 32K to 4G
// - Entry masks operating-system interrupts and exceptions
// - Resume reloads saved state, leaves mode
// - Revision identifier always sets bit 17
// - Base changes only via resumed image
// - No translation, 16-bit sizes, selector shifted four
// - Without override highest address is 10FFEFh
// - Default base gives code selector 3000h
// - Base stays below 4G, extension off
// - Fault address register never saved or restored
// - System backs top 32K with memory
// - System routes memory by mode entry, exit
// - Restart indicators held one byte each
// - No external flush input pin provided
module sme_core_end #(
    parameter int SAVE_WORDS = sme_pkg::SAVE_WORDS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    sme_link_if.core link,
    input wire logic instr_boundary,
    input wire logic resume_exec,
    input wire logic [31:0] save_word,
    input wire logic [7:0] io_restart_byte,
    input wire logic [7:0] halt_restart_byte,
    input wire logic [15:0] seg_sel,
    input wire logic [31:0] seg_off,
    input wire logic addr_override,
    output logic [sme_pkg::IDX_W-1:0] save_idx,
    output logic in_mgmt,
    output logic ints_masked,
    output logic xlat_off,
    output logic addr16_default,
    output logic [15:0] cs_selector,
    output logic [31:0] cs_base,
    output logic [31:0] fetch_addr,
    output logic fetch_go,
    output logic [31:0] mgmt_base_address,
    output logic rst_valid,
    output logic [sme_pkg::IDX_W-1:0] rst_idx,
    output logic [31:0] rst_word,
    output logic [7:0] io_restart_flag,
    output logic [7:0] halt_restart_flag,
    output logic [31:0] lin_addr,
    output logic resumed
);
    typedef enum logic [2:0] {
        SME_IDLE,
        SME_SAVE,
        SME_HANDLER,
        SME_RESTORE,
        SME_EXIT
    } sme_state_t;

    sme_state_t state;
    logic [sme_pkg::IDX_W-1:0] idx;
    logic [31:0] pend_base;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic mode_flag;

    // no flush input
    // Only the link and the user ports above exist; no cache flush pin
    wire last_word = (idx == 7'(SAVE_WORDS - 1));
    wire take_irq = link.mgmt_interrupt && instr_boundary && (state == SME_IDLE);
    wire issue = !mem_req && !link.mem_ack;

    wire [31:0] save_area = mgmt_base_address + sme_pkg::SAVE_OFS;
    wire [31:0] word_addr = save_area + {23'h0, idx, 2'h0};

    wire [31:0] rev_word = sme_pkg::REV_ID_CODE | (32'h1 << sme_pkg::REV_RELOC_BIT);

    wire [31:0] restart_word = {16'h0, halt_restart_byte, io_restart_byte};

    // fault address not stored
    // Save data: fixed fields at their indices, the rest from the core
    wire [31:0] out_word = (idx == sme_pkg::IDX_REVISION) ? rev_word :
                           (idx == sme_pkg::IDX_BASE) ? mgmt_base_address :
                           (idx == sme_pkg::IDX_RESTART) ? restart_word : save_word;

    wire [31:0] seg_base = {12'h0, seg_sel, 4'h0};
    wire [sme_pkg::REAL_ADDR_W-1:0] real_addr =
        sme_pkg::REAL_ADDR_W'(seg_base) + sme_pkg::REAL_ADDR_W'(seg_off[15:0]);
    wire [31:0] next_lin = addr_override ? (seg_base + seg_off)
                                         : {11'h0, real_addr};

    wire [15:0] next_cs = mgmt_base_address[19:4];

    // Main sequence: recognize, save, handler, restore, exit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= SME_IDLE;
            idx <= '0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 32'h0;
            mem_wdata <= 32'h0;
            fetch_go <= 1'b0;
            resumed <= 1'b0;
            rst_valid <= 1'b0;
        end else if (ce) begin
            fetch_go <= 1'b0;
            resumed <= 1'b0;
            rst_valid <= 1'b0;
            unique case (state)
                SME_IDLE: begin
                    if (take_irq) begin
                        state <= SME_SAVE;
                        idx <= '0;
                    end
                end
                SME_SAVE: begin
                    if (issue) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b1;
                        mem_addr <= word_addr;
                        mem_wdata <= out_word;
                    end else if (mem_req && link.mem_ack) begin
                        mem_req <= 1'b0;
                        if (last_word) begin
                            state <= SME_HANDLER;
                            fetch_go <= 1'b1;
                        end else begin
                            idx <= idx + 7'h1;
                        end
                    end
                end
                SME_HANDLER: begin
                    if (resume_exec) begin
                        state <= SME_RESTORE;
                        idx <= '0;
                    end
                end
                SME_RESTORE: begin
                    if (issue) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_addr <= word_addr;
                    end else if (mem_req && link.mem_ack) begin
                        mem_req <= 1'b0;
                        rst_valid <= 1'b1;
                        if (last_word) begin
                            state <= SME_EXIT;
                        end else begin
                            idx <= idx + 7'h1;
                        end
                    end
                end
                SME_EXIT: begin
                    state <= SME_IDLE;
                    resumed <= 1'b1;
                end
            endcase
        end
    end

    // Restored word, restart bytes and pending base capture
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_idx <= '0;
            rst_word <= 32'h0;
            io_restart_flag <= 8'h0;
            halt_restart_flag <= 8'h0;
            pend_base <= sme_pkg::BASE_RESET;
        end else if (ce && state == SME_RESTORE && mem_req && link.mem_ack) begin
            rst_idx <= idx;
            rst_word <= link.mem_rdata;
            if (idx == sme_pkg::IDX_RESTART) begin
                io_restart_flag <= link.mem_rdata[7:0];
                halt_restart_flag <= link.mem_rdata[15:8];
            end
            if (idx == sme_pkg::IDX_BASE) begin
                pend_base <= link.mem_rdata;
            end
        end
    end

    // Base register, mode flags and code segment
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mgmt_base_address <= sme_pkg::BASE_RESET;
            mode_flag <= 1'b0;
            ints_masked <= 1'b0;
            cs_selector <= 16'h0;
            cs_base <= 32'h0;
            fetch_addr <= 32'h0;
        end else if (ce) begin
            if (take_irq) begin
                mode_flag <= 1'b1;
                ints_masked <= 1'b1;
                cs_selector <= next_cs;
                cs_base <= mgmt_base_address;
                fetch_addr <= mgmt_base_address + sme_pkg::ENTRY_OFS;
            end
            if (state == SME_EXIT) begin
                mode_flag <= 1'b0;
                ints_masked <= 1'b0;
                mgmt_base_address <= pend_base;
            end
        end
    end

    // Addressing in mode: translation off, 16-bit defaults
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lin_addr <= 32'h0;
        end else if (ce) begin
            lin_addr <= next_lin;
        end
    end

    assign xlat_off = mode_flag;
    assign addr16_default = mode_flag;
    assign in_mgmt = mode_flag;
    assign save_idx = idx;
    assign link.system_mgmt_mode = mode_flag;
    assign link.mem_req = mem_req;
    assign link.mem_we = mem_we;
    assign link.mem_addr = mem_addr;
    assign link.mem_wdata = mem_wdata;
endmodule : sme_core_end

// File: sme_sys_end.sv
// System end: raises management interrupt and steers memory to the region
module sme_sys_end #(
    parameter longint REGION_BYTES = sme_pkg::REGION_DEFAULT,
    parameter logic [31:0] REGION_BASE = sme_pkg::BASE_RESET
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    sme_link_if.sys link,
    input wire logic raise_mgmt,
    output logic route_mgmt,
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [31:0] mem_addr_o,
    output logic [31:0] mem_wdata_o,
    input wire logic [31:0] mem_rdata_i,
    input wire logic mem_ack_i,
    output logic region_miss
);
    localparam bit SIZE_OK = (REGION_BYTES >= sme_pkg::REGION_MIN)
                          && (REGION_BYTES <= sme_pkg::REGION_MAX);
    localparam longint REGION_USE = SIZE_OK ? REGION_BYTES : sme_pkg::REGION_DEFAULT;

    logic busy;
    logic irq;
    logic ack;
    logic [31:0] rdata;

    wire [31:0] top_lo = 32'(64'(REGION_BASE) + REGION_USE - 64'(sme_pkg::BACKED_BYTES));
    wire [32:0] top_hi = 33'(64'(REGION_BASE) + REGION_USE);
    wire in_top = (link.mem_addr >= top_lo) && ({1'b0, link.mem_addr} < top_hi);
    wire start = !busy && link.mem_req;

    // Interrupt request held until the core shows entry; set wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= raise_mgmt || (irq && !link.system_mgmt_mode);
        end
    end

    // One transaction at a time toward the memory port
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
            ack <= 1'b0;
            rdata <= 32'h0;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= 32'h0;
            mem_wdata_o <= 32'h0;
            region_miss <= 1'b0;
            route_mgmt <= 1'b0;
        end else if (ce) begin
            ack <= 1'b0;
            route_mgmt <= link.system_mgmt_mode;
            if (start) begin
                busy <= 1'b1;
                mem_req_o <= 1'b1;
                mem_we_o <= link.mem_we;
                mem_addr_o <= link.mem_addr;
                mem_wdata_o <= link.mem_wdata;
                region_miss <= link.system_mgmt_mode && !in_top;
            end else if (mem_req_o && mem_ack_i) begin
                mem_req_o <= 1'b0;
                ack <= 1'b1;
                rdata <= mem_rdata_i;
            end else if (busy && !mem_req_o && !ack && !link.mem_req) begin
                busy <= 1'b0;
            end
        end
    end

    assign link.mgmt_interrupt = irq;
    assign link.mem_ack = ack;
    assign link.mem_rdata = rdata;
endmodule : sme_sys_end

// File: sme_link_sva.sv
// Link-side checker for management-mode entry, state save and resume
module sme_link_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic mgmt_interrupt,
    input wire logic system_mgmt_mode,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack
);
    logic [31:0] base_q;
    logic [31:0] base_img;
    logic [7:0] wcnt;
    logic [7:0] rcnt;
    logic mode_d;
    wire logic [31:0] ofs = mem_addr - base_q;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // Base image read back on restore, word counts per session
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            base_q <= sme_pkg::BASE_RESET;
            base_img <= sme_pkg::BASE_RESET;
            wcnt <= 8'h00;
            rcnt <= 8'h00;
            mode_d <= 1'b0;
        end else begin
            mode_d <= system_mgmt_mode;
            if (mem_ack && !mem_we && ofs == 32'h0000_ff00) begin
                base_img <= mem_rdata;
            end
            if (mode_d && !system_mgmt_mode) begin
                base_q <= base_img;
            end
            wcnt <= system_mgmt_mode ? wcnt + {7'h00, mem_ack & mem_we} : 8'h00;
            rcnt <= system_mgmt_mode ? rcnt + {7'h00, mem_ack & ~mem_we} : 8'h00;
        end
    end
    a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
        && $stable(mem_we) && $stable(mem_wdata)) else $error("request changed before ack");
    a_save_window: assert property (mem_req |-> ofs >= 32'h0000_fe00
        && ofs <= 32'h0000_fffc && mem_addr[1:0] == 2'b00) else $error("access outside save area");
    a_save_order: assert property ($rose(mem_req) && mem_we |->
        ofs == 32'h0000_fe00 + {22'h0, wcnt, 2'b00}) else $error("save word out of order");
    a_restore_order: assert property ($rose(mem_req) && !mem_we |-> wcnt == 8'd128
        && ofs == 32'h0000_fe00 + {22'h0, rcnt, 2'b00}) else $error("restore out of order");
    a_exit_restored: assert property ($fell(system_mgmt_mode) |-> rcnt == 8'd128)
        else $error("exit before full restore");
    a_entry_on_irq: assert property ($rose(system_mgmt_mode) |-> $past(mgmt_interrupt))
        else $error("mode entered without interrupt");
    a_rev_reloc: assert property (mem_req && mem_we && ofs == 32'h0000_fefc |-> mem_wdata[17])
        else $error("relocation bit clear");
    a_base_image: assert property (mem_req && mem_we && ofs == 32'h0000_ff00
        |-> mem_wdata == base_q) else $error("saved base differs");
endmodule : sme_link_sva

// File: system_mgmt_mode_entry_exit_tb_top.sv
// Bench driving both ends of the management-mode link
module system_mgmt_mode_entry_exit_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, nrst, ib, rx, ov, rq, ack_i, hold, inm, msk, xo, a16, fgo, mgmt_resume_instruction, rte, mreq, mwe;
    logic ce, rv, rmiss;
    logic [6:0] sidx, ri;
    logic [31:0] sw, off, rd_i, wd_o, addr_o, base_e, csb, fa, mba, lin, rnd, mst, rw;
    logic [31:0] mem [128];
    logic [15:0] sel, css;
    logic [7:0] io_b, ht_b, io_f, ht_f;
    int failures, tests_run, wn, rn;
    sme_link_if lnk ();
    sme_core_end i_sme_core_end (.clk(clk), .nrst(nrst), .ce(ce), .link(lnk.core),
        .instr_boundary(ib), .resume_exec(rx), .save_word(sw), .io_restart_byte(io_b),
        .halt_restart_byte(ht_b), .seg_sel(sel), .seg_off(off), .addr_override(ov),
        .save_idx(sidx), .in_mgmt(inm), .ints_masked(msk), .xlat_off(xo), .addr16_default(a16),
        .cs_selector(css), .cs_base(csb), .fetch_addr(fa), .fetch_go(fgo),
        .mgmt_base_address(mba), .rst_valid(rv), .rst_idx(ri), .rst_word(rw),
        .io_restart_flag(io_f), .halt_restart_flag(ht_f), .lin_addr(lin), .resumed(mgmt_resume_instruction));
    sme_sys_end i_sme_sys_end (.clk(clk), .nrst(nrst), .ce(ce), .link(lnk.sys),
        .raise_mgmt(rq), .route_mgmt(rte), .mem_req_o(mreq), .mem_we_o(mwe),
        .mem_addr_o(addr_o), .mem_wdata_o(wd_o), .mem_rdata_i(rd_i), .mem_ack_i(ack_i),
        .region_miss(rmiss));
    sme_link_sva i_sme_link_sva (.clk(clk), .nrst(nrst), .mgmt_interrupt(lnk.mgmt_interrupt),
        .system_mgmt_mode(lnk.system_mgmt_mode), .mem_req(lnk.mem_req), .mem_we(lnk.mem_we),
        .mem_addr(lnk.mem_addr), .mem_wdata(lnk.mem_wdata), .mem_rdata(lnk.mem_rdata),
        .mem_ack(lnk.mem_ack));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    // Segment shifted four, 21-bit wrap unless overridden
    function automatic logic [31:0] lin_exp(input logic [15:0] s, input logic [31:0] o,
        input logic v);
        logic [31:0] b;
        b = {12'h000, s, 4'h0};
        return v ? b + o : {11'h000, b[20:0] + {5'h00, o[15:0]}};
    endfunction : lin_exp
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    task automatic wait_hi(ref logic sig);
        int n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (sig !== 1'b1 && n < 3000);
        check(sig, 1'b1);
    endtask : wait_hi
    // Entry, addressing and resume with a new base image
    task automatic session(input logic [31:0] nb);
        wn = 0;
        rn = 0;
        rnd = xs(rnd);
        @(posedge clk);
        rq <= 1'b1;
        {ht_b, io_b} <= rnd[15:0];
        @(posedge clk);
        rq <= 1'b0;
        repeat (4) @(negedge clk);
        check({inm, lnk.mgmt_interrupt}, 2'b01);
        @(posedge clk);
        ib <= 1'b1;
        wait_hi(inm);
        @(posedge clk);
        ib <= 1'b0;
        check({msk, xo, a16}, 3'b111);
        check(fa, base_e + sme_pkg::ENTRY_OFS);
        check(css, base_e[19:4]);
        if (base_e == sme_pkg::BASE_RESET) check(csb, 32'h0003_0000);
        wait_hi(fgo);
        check(wn, 128);
        for (int i = 0; i < 6; i++) begin
            rnd = xs(rnd);
            @(posedge clk);
            sel <= i == 0 ? 16'hffff : rnd[15:0];
            off <= i == 0 ? 32'h0000_ffff : {rnd[7:0], rnd[31:8]};
            ov <= i > 2;
            repeat (2) @(negedge clk);
            check(lin, lin_exp(sel, off, ov));
        end
        // Clock enable low freezes the registered address
        @(posedge clk);
        ce <= 1'b0;
        sel <= ~sel;
        repeat (3) @(negedge clk);
        check(lin, lin_exp(~sel, off, ov));
        @(posedge clk);
        ce <= 1'b1;
        check(mba, base_e);
        rnd = xs(rnd);
        mem[7'h40] = nb;
        mem[7'h32] = {16'h0000, rnd[15:0]};
        @(posedge clk);
        rx <= 1'b1;
        @(posedge clk);
        rx <= 1'b0;
        wait_hi(mgmt_resume_instruction);
        check(mba, nb);
        check({inm, msk}, 2'b00);
        check({ht_f, io_f}, rnd[15:0]);
        repeat (2) @(negedge clk);
        check(rte, 1'b0);
        $display("Session at base %h done", base_e);
        base_e = nb;
    endtask : session
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Three sessions of about 1400 cycles each fit well inside this span
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run();
    end
    // Memory answering forwarded requests with random stalls
    always @(posedge clk) begin
        mst <= xs(mst);
        sw <= mst;
        ack_i <= 1'b0;
        if (!mreq) begin
            hold <= 1'b0;
        end else if (!hold && mst[1:0] != 2'b00) begin
            hold <= 1'b1;
            ack_i <= 1'b1;
            check(rte, 1'b1);
            check(sidx, mwe ? wn : rn);
            check(rmiss, addr_o < 32'h0003_8000 || addr_o > 32'h0003_ffff);
            if (mwe) begin
                check(addr_o, base_e + sme_pkg::SAVE_OFS + 32'(wn << 2));
                mem[wn] = wd_o;
                if (wn == 'h32) check(wd_o, {16'h0000, ht_b, io_b});
                if (wn == 'h3f) check(wd_o[17], 1'b1);
                if (wn == 'h40) check(wd_o, base_e);
                wn++;
            end else begin
                check(addr_o, base_e + sme_pkg::SAVE_OFS + 32'(rn << 2));
                rd_i <= mem[rn];
                rn++;
            end
        end
    end
    // Each restored word matches the image handed to the core
    always @(negedge clk) begin
        if (rv === 1'b1) begin
            check(rw, mem[ri]);
        end
    end
    initial begin
        {nrst, ib, rx, ov, rq} = 5'h00;
        ce = 1'b1;
        {sel, off, io_b, ht_b} = '0;
        rnd = 32'hb6b7;
        mst = 32'hb6b7;
        base_e = sme_pkg::BASE_RESET;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check(mba, sme_pkg::BASE_RESET);
        for (int k = 0; k < 2; k++) begin
            rnd = xs(rnd);
            session({4'h0, rnd[11:0], 16'h0000});
        end
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        check(mba, sme_pkg::BASE_RESET);
        $display("Mid-run reset done");
        base_e = sme_pkg::BASE_RESET;
        session(sme_pkg::BASE_RESET);
        complete_run();
    end
endmodule : system_mgmt_mode_entry_exit_tb_top
